/* design/dsh_bank.sv */
// drive status history bank: six sticky history words, engine status, mode display
// assumes live status words, engine state and mode come from logic on i_mclk
`timescale 1ns/1ps
`default_nettype none

module dsh_bank
    import dsh_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // parameter access port
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_rvalid,
    output logic o_rerr,
    // live status words, same bit-field map for each
    input wire logic [DATA_W-1:0] i_live_bridge,
    input wire logic [DATA_W-1:0] i_live_drv_prot,
    input wire logic [DATA_W-1:0] i_live_sys_prot,
    input wire logic [DATA_W-1:0] i_live_sys_one,
    input wire logic [DATA_W-1:0] i_live_sys_two,
    input wire logic [DATA_W-1:0] i_live_sys_three,
    // motion engine and mode sources
    input wire logic [7:0] i_active_seq,
    input wire logic [3:0] i_me_state,
    input wire logic [7:0] i_op_mode,
    // summary of history words
    output logic o_hist_any
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // history word index for an address, HIST_N when not a history word
    function automatic logic [2:0] hist_index(input logic [ADDR_W-1:0] addr);
        logic [2:0] idx;
        idx = 3'(HIST_N);
        if (addr == OFS_EVENT_HIST) begin
            idx = 3'd0;
        end else if (addr == OFS_DRV_PROT_HIST) begin
            idx = 3'd1;
        end else if (addr == OFS_SYS_PROT_HIST) begin
            idx = 3'd2;
        end else if (addr == OFS_SYS_ONE_HIST) begin
            idx = 3'd3;
        end else if (addr == OFS_SYS_TWO_HIST) begin
            idx = 3'd4;
        end else if (addr == OFS_SYS_THREE_HIST) begin
            idx = 3'd5;
        end
        return idx;
    endfunction

    // clamp an engine code onto the defined states
    function automatic dsh_me_state_t me_code(input logic [3:0] raw);
        dsh_me_state_t st;
        st = ME_USER_FAULT;
        if (raw <= 4'(ME_USER_FAULT)) begin
            st = dsh_me_state_t'(raw);
        end
        return st;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // gather the live words in one indexed array
    logic [DATA_W-1:0] live_w [HIST_N];

    assign live_w[0] = i_live_bridge;
    assign live_w[1] = i_live_drv_prot;
    assign live_w[2] = i_live_sys_prot;
    assign live_w[3] = i_live_sys_one;
    assign live_w[4] = i_live_sys_two;
    assign live_w[5] = i_live_sys_three;

    ////////////////////////////////////////////////////////////////////////////
    // address decode for the access port
    logic [2:0] wr_idx;
    logic [2:0] rd_idx;
    logic rd_is_seq;
    logic rd_is_rsvd;
    logic rd_is_me;
    logic rd_is_mode;
    logic rd_is_hist;
    logic rd_hit;

    assign wr_idx = i_wr ? hist_index(i_addr) : 3'(HIST_N);
    assign rd_idx = hist_index(i_addr);
    assign rd_is_hist = (rd_idx != 3'(HIST_N));
    assign rd_is_seq = (i_addr == OFS_ACTIVE_SEQ);
    assign rd_is_rsvd = (i_addr == OFS_RSVD_A) || (i_addr == OFS_RSVD_B);
    assign rd_is_me = (i_addr == OFS_ME_STATE);
    assign rd_is_mode = (i_addr == OFS_MODE_DISP);
    assign rd_hit = rd_is_hist || rd_is_seq || rd_is_rsvd || rd_is_me || rd_is_mode;

    ////////////////////////////////////////////////////////////////////////////
    // history words: one generate slice per live word
    logic [DATA_W-1:0] live_q [HIST_N];
    logic [DATA_W-1:0] hist_q [HIST_N];
    logic [DATA_W-1:0] hist_d [HIST_N];
    logic [DATA_W-1:0] fall_w [HIST_N];
    logic [DATA_W-1:0] clr_w [HIST_N];
    logic [HIST_N-1:0] nonzero_w;

    genvar gi;
    generate
        for (gi = 0; gi < HIST_N; gi++) begin : g_hist
            // an event that was active last cycle and is inactive now has completed
            assign fall_w[gi] = live_q[gi] & ~live_w[gi];
            // ones in the write data clear, zeros leave the bit alone
            assign clr_w[gi] = (wr_idx == 3'(gi)) ? i_wdata : RST_HIST;
            // set beats clear, bits stay set otherwise
            assign hist_d[gi] = (hist_q[gi] & ~clr_w[gi]) | fall_w[gi];
            assign nonzero_w[gi] = |hist_q[gi];

            // previous live level and the sticky word
            always_ff @(posedge i_mclk) begin
                if (!i_rst_b) begin
                    live_q[gi] <= RST_HIST;
                    hist_q[gi] <= RST_HIST;
                end else begin
                    live_q[gi] <= live_w[gi];
                    hist_q[gi] <= hist_d[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // motion engine status capture
    dsh_me_state_t me_q;
    dsh_me_state_t me_d;
    logic [7:0] mode_q;
    logic [7:0] seq_q;
    logic [7:0] seq_d;
    logic seq_in_range;

    // engine codes pass through, unknown codes report as user fault
    assign me_d = me_code(i_me_state);

    // sequence number is shown only while the engine runs sequences
    assign seq_in_range = (i_active_seq <= SEQ_MAX_INDEX) || (i_active_seq == SEQ_DYNAMIC);
    assign seq_d = ((i_op_mode == MODE_ENGINE) && seq_in_range) ? i_active_seq : SEQ_NONE;

    // captured status words, read-only to the host
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            me_q <= ME_INACTIVE;
            mode_q <= RST_MODE;
            seq_q <= SEQ_NONE;
        end else begin
            me_q <= me_d;
            mode_q <= i_op_mode;
            seq_q <= seq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data selection
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] seq_word;
    logic [DATA_W-1:0] me_word;
    logic [DATA_W-1:0] mode_word;

    assign seq_word = {8'h00, seq_q};
    assign me_word = {12'h000, 4'(me_q)};
    assign mode_word = {8'h00, mode_q};

    always_comb begin
        rd_mux = RST_WORD;
        if (rd_is_hist) begin
            rd_mux = hist_q[rd_idx];
        end else if (rd_is_seq) begin
            rd_mux = seq_word;
        end else if (rd_is_me) begin
            rd_mux = me_word;
        end else if (rd_is_mode) begin
            rd_mux = mode_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered answer, one cycle after the read strobe
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_rdata <= RST_WORD;
            o_rvalid <= 1'b0;
            o_rerr <= 1'b0;
            o_hist_any <= 1'b0;
        end else begin
            o_rvalid <= i_rd;
            o_rerr <= i_rd && !rd_hit;
            o_rdata <= i_rd ? rd_mux : RST_WORD;
            o_hist_any <= |nonzero_w;
        end
    end

endmodule

`default_nettype wire

/* design/dsh_pkg.sv */
// package of constants for the drive status history bank
// assumes one 20 MHz clock and a word-wide parameter access port
//
// Contract
// - history bit sets when its live event rises and then falls again
// - a history bit of one means the event happened; all bits start at zero
// - writing one to a history bit clears it; otherwise history is read only
// - six 16-bit history words, each bit following the same bit of its live word
// - live words share one sixteen-position bit-field map, unused positions reserved
// - active sequence low byte: 0 to 15, fe dynamic, ff none; upper byte reserved
// - active sequence is meaningful only while the motion engine sequences
// - engine states 0 inactive, 1 waiting, 2 executing, 3 program load
// - state 4 is a load crc failure, held until the host resets the engine
// - state 5 halt, 6 single step, 7 breakpoint, 8 no errors
// - states 9 and 10 are load faults needing an engine reset by the host
// - state 11 bad op-code for dynamic motion, 12 bad reference frame
// - state 13 bridge disabled at index start, 14 user defined fault
// - mode display 1,3,4,6,7 for the profile, homing and interpolated modes
// - mode display 8c jog, 9e cfg0, de cfg1, ec engine, ff none
package dsh_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam int HIST_N = 6;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets (word index on the access port)
    localparam logic [9:0] OFS_EVENT_HIST = 10'h00b;
    localparam logic [9:0] OFS_DRV_PROT_HIST = 10'h00c;
    localparam logic [9:0] OFS_SYS_PROT_HIST = 10'h00d;
    localparam logic [9:0] OFS_SYS_ONE_HIST = 10'h00e;
    localparam logic [9:0] OFS_SYS_TWO_HIST = 10'h00f;
    localparam logic [9:0] OFS_SYS_THREE_HIST = 10'h010;
    localparam logic [9:0] OFS_ACTIVE_SEQ = 10'h0c2;
    localparam logic [9:0] OFS_RSVD_A = 10'h0c3;
    localparam logic [9:0] OFS_RSVD_B = 10'h0c4;
    localparam logic [9:0] OFS_ME_STATE = 10'h0c5;
    localparam logic [9:0] OFS_MODE_DISP = 10'h392;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [15:0] RST_HIST = 16'h0000;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_MODE = 8'hff;

    ////////////////////////////////////////////////////////////////////////////
    // active sequence field
    localparam int SEQ_LSB = 0;
    localparam int SEQ_MSB = 7;
    localparam logic [7:0] SEQ_MAX_INDEX = 8'h0f;
    localparam logic [7:0] SEQ_DYNAMIC = 8'hfe;
    localparam logic [7:0] SEQ_NONE = 8'hff;

    ////////////////////////////////////////////////////////////////////////////
    // motion engine states
    typedef enum logic [3:0] {
        ME_INACTIVE = 4'b0000,
        ME_WAIT_START = 4'b0001,
        ME_EXECUTING = 4'b0010,
        ME_PROG_LOAD = 4'b0011,
        ME_LOAD_CRC_FAIL = 4'b0100,
        ME_HALTED = 4'b0101,
        ME_SINGLE_STEP = 4'b0110,
        ME_BREAKPOINT = 4'b0111,
        ME_NO_ERRORS = 4'b1000,
        ME_BAD_DATA_PARAM = 4'b1001,
        ME_BAD_OPCODE = 4'b1010,
        ME_BAD_DYN_OPCODE = 4'b1011,
        ME_BAD_REF_FRAME = 4'b1100,
        ME_BRIDGE_OFF = 4'b1101,
        ME_USER_FAULT = 4'b1110
    } dsh_me_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // operating mode display codes
    localparam logic [7:0] MODE_PROF_POS = 8'h01;
    localparam logic [7:0] MODE_PROF_VEL = 8'h03;
    localparam logic [7:0] MODE_PROF_CUR = 8'h04;
    localparam logic [7:0] MODE_HOMING = 8'h06;
    localparam logic [7:0] MODE_INTERP_POS = 8'h07;
    localparam logic [7:0] MODE_JOG = 8'h8c;
    localparam logic [7:0] MODE_CFG0 = 8'h9e;
    localparam logic [7:0] MODE_CFG1 = 8'hde;
    localparam logic [7:0] MODE_ENGINE = 8'hec;
    localparam logic [7:0] MODE_NONE = 8'hff;

endpackage

/* tb/dsh_bank_monitor.sv */
// checker of the history bank access port and of one history word
// assumes one clock i_mclk and synchronous active-low i_rst_b
`timescale 1ns/1ps
`default_nettype none
module dsh_bank_monitor
    import dsh_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_rd,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_live_bridge,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic o_rerr
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////////////////////////////////////////
    // falls of the live bridge word, previous level cleared in reset
    logic [15:0] prev_q;
    logic [15:0] fall_q;
    always_ff @(posedge i_mclk) begin
        prev_q <= i_rst_b ? i_live_bridge : 16'h0000;
        fall_q <= i_rst_b ? (prev_q & ~i_live_bridge) : 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_ans; i_rd |=> o_rvalid; endproperty
    a_ans: assert property (p_ans) else $error("read not answered");
    property p_no_ans; !i_rd |=> !o_rvalid && !o_rerr; endproperty
    a_no_ans: assert property (p_no_ans) else $error("answer without read");
    property p_err; o_rerr |-> o_rvalid && o_rdata == 16'h0000; endproperty
    a_err: assert property (p_err) else $error("error answer malformed");
    property p_idle; !o_rvalid |-> o_rdata == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("read data while idle");
    property p_rsvd; i_rd && (i_addr == OFS_RSVD_A || i_addr == OFS_RSVD_B) |=> o_rdata == 16'h0000 && !o_rerr;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved slot not zero");
    property p_state; i_rd && i_addr == OFS_ME_STATE |=> o_rdata[15:4] == 12'h000 && o_rdata[3:0] != 4'hf;
    endproperty
    a_state: assert property (p_state) else $error("engine state out of range");
    property p_byte; i_rd && (i_addr == OFS_MODE_DISP || i_addr == OFS_ACTIVE_SEQ) |=> o_rdata[15:8] == 8'h00;
    endproperty
    a_byte: assert property (p_byte) else $error("upper byte not zero");
    property p_set; i_rd && i_addr == OFS_EVENT_HIST |=> (o_rdata & $past(fall_q)) == $past(fall_q); endproperty
    a_set: assert property (p_set) else $error("history event lost");
endmodule
bind dsh_bank dsh_bank_monitor u_mon (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_rd(i_rd), .i_addr(i_addr),
    .i_live_bridge(i_live_bridge), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_rerr(o_rerr));
`default_nettype wire

/* tb/dsh_host.sv */
// network host model: issues parameter reads and writes
// assumes the bank samples requests on the rising edge of i_mclk
`timescale 1ns/1ps
`default_nettype none
module dsh_host
    import dsh_pkg::*;
(
    input wire logic i_mclk,
    output logic o_wr,
    output logic o_rd,
    output logic [ADDR_W-1:0] o_addr,
    output logic [DATA_W-1:0] o_wdata
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = '0;
        o_wdata = '0;
    end
    // one request held across one rising edge; ones in data clear history
    task automatic access(input logic wr, input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge i_mclk);
        o_wr = wr;
        o_rd = rd;
        o_addr = a;
        o_wdata = d;
    endtask
    // release: strobes low, lines no longer hold the last value
    task automatic idle();
        @(negedge i_mclk);
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = ~o_addr;
        o_wdata = ~o_wdata;
    endtask
endmodule
`default_nettype wire

/* tb/test_drive_status_history_bank.sv */
// self-checking bench of the history bank against a cycle model
// assumes the bank answers reads one cycle later
`timescale 1ns/1ps
`default_nettype none
module test_drive_status_history_bank;
    import dsh_pkg::*;
    localparam logic [9:0] TAB [12] = '{10'h00b, 10'h00c, 10'h00d, 10'h00e, 10'h00f, 10'h010,
        10'h0c2, 10'h0c3, 10'h0c4, 10'h0c5, 10'h392, 10'h3ff};
    localparam logic [7:0] MODES [10] = '{8'h01, 8'h03, 8'h04, 8'h06, 8'h07, 8'h8c, 8'h9e, 8'hde, 8'hec, 8'hff};
    logic clk = 1'b0, rst_b = 1'b0, h_wr, h_rd, o_rvalid, o_rerr, o_hist_any, ev = 1'b0, ee = 1'b0, ha = 1'b0;
    logic [9:0] h_addr;
    logic [15:0] h_wdata, o_rdata, ed = 16'h0000, live [6], hist [6], prev [6];
    logic [7:0] seq = 8'h00, mode = 8'h00, md_m, sq_m;
    logic [3:0] st = 4'h0, st_m;
    int n_fail = 0, n_compared = 0, seed_v;
    always #25 clk = ~clk;
    dsh_host host (.i_mclk(clk), .o_wr(h_wr), .o_rd(h_rd), .o_addr(h_addr), .o_wdata(h_wdata));
    dsh_bank dut (.i_mclk(clk), .i_rst_b(rst_b), .i_wr(h_wr), .i_rd(h_rd), .i_addr(h_addr), .i_wdata(h_wdata),
        .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_rerr(o_rerr), .i_live_bridge(live[0]), .i_live_drv_prot(live[1]),
        .i_live_sys_prot(live[2]), .i_live_sys_one(live[3]), .i_live_sys_two(live[4]), .i_live_sys_three(live[5]),
        .i_active_seq(seq), .i_me_state(st), .i_op_mode(mode), .o_hist_any(o_hist_any));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        if (n_fail == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // cycle model: read answer from pre-write state, then history update
    always @(posedge clk) begin
        ev = rst_b && h_rd;
        ee = 1'b0;
        ed = 16'h0000;
        // summary flag shows the history words as they stood before this edge
        ha = 1'b0;
        foreach (hist[i]) ha = ha | (rst_b && hist[i] != 16'h0000);
        if (ev) begin
            case (h_addr)
                OFS_ACTIVE_SEQ: ed = {8'h00, (md_m == 8'hec && (sq_m <= 8'h0f || sq_m == 8'hfe)) ? sq_m : 8'hff};
                OFS_RSVD_A, OFS_RSVD_B: ed = 16'h0000;
                OFS_ME_STATE: ed = {12'h000, st_m};
                OFS_MODE_DISP: ed = {8'h00, md_m};
                default: if (h_addr >= 10'h00b && h_addr <= 10'h010) ed = hist[h_addr - 10'h00b]; else ee = 1'b1;
            endcase
        end
        for (int i = 0; i < 6; i++) begin
            if (!rst_b) hist[i] = 16'h0000;
            else hist[i] = (hist[i] & ~((h_wr && h_addr == 10'h00b + i) ? h_wdata : 16'h0000))
                | (prev[i] & ~live[i]);
            prev[i] = rst_b ? live[i] : 16'h0000;
        end
        st_m = !rst_b ? 4'h0 : (st == 4'hf) ? 4'he : st;
        md_m = rst_b ? mode : 8'hff;
        sq_m = rst_b ? seq : 8'hff;
    end
    // comparison of every answer with the model
    always @(negedge clk) begin
        chk("rvalid", {15'h0000, o_rvalid}, {15'h0000, ev});
        chk("rerr", {15'h0000, o_rerr}, {15'h0000, ee});
        chk("rdata", o_rdata, ed);
        chk("hist_any", {15'h0000, o_hist_any}, {15'h0000, ha});
    end
    task automatic read_all();
        foreach (TAB[j]) host.access(1'b0, 1'b1, TAB[j], 16'h0000);
        host.idle();
    endtask
    initial begin
        #(50 * 20000);
        n_fail++;
        end_sim();
    end
    initial begin
        foreach (live[i]) live[i] = 16'h0000;
        seed_v = $urandom(32'h2e94);
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        read_all();
        // engine state, mode and sequence codes, with writes to read-only places
        for (int k = 0; k < 16; k++) begin
            @(negedge clk);
            st = k[3:0];
            mode = (k >= 14) ? 8'hec : MODES[k % 10];
            seq = (k == 15) ? 8'hfe : (k == 14) ? 8'h10 : k[7:0];
            host.idle();
            host.access(1'b1, 1'b1, 10'h0c5, 16'hffff);
            host.access(1'b1, 1'b1, 10'h0c2, 16'hffff);
            host.access(1'b1, 1'b1, 10'h392, 16'h0000);
            host.idle();
        end
        // random live events against random back-to-back accesses
        repeat (3000) begin
            foreach (live[i]) live[i] = $urandom & $urandom;
            host.access($urandom % 2, $urandom % 2, TAB[$urandom % 12], $urandom & $urandom);
        end
        host.idle();
        @(negedge clk);
        rst_b = 1'b0;
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        read_all();
        end_sim();
    end
endmodule
`default_nettype wire
